// ===== core/dmac_alu.sv
// Lane-split adder/subtractor and ten-function logic unit of the slice.
// Assumes the caller registers the result; this module is purely combinational.
`timescale 1ns/100ps
`include "dmac_defines.svh"

module dmac_alu
  import dmac_pkg::*;
(
  input wire logic [`DMAC_P_W-1:0] x,
  input wire logic [`DMAC_P_W-1:0] z,
  input wire dmac_simd_t simd,
  input wire logic sub,
  input wire logic logic_en,
  input wire dmac_lfn_t lfn,
  output logic [`DMAC_P_W-1:0] res,
  output logic [`DMAC_LANES-1:0] carry
);

  // -------------------------------------------------------------------------
  // Decoding helpers
  // -------------------------------------------------------------------------
  // A lane starts a fresh carry chain when the selected split puts a boundary there.
  function automatic logic lane_break(input int i, input dmac_simd_t s);
    if (i == 2) begin
      return s != DMAC_ONE48;
    end
    return ((i % 2) == 1) && (s == DMAC_FOUR12);
  endfunction

  function automatic logic [`DMAC_P_W-1:0] lfn_eval(input dmac_lfn_t f,
      input logic [`DMAC_P_W-1:0] a, input logic [`DMAC_P_W-1:0] b);
    case (f)
      DMAC_L_AND: return a & b;
      DMAC_L_OR: return a | b;
      DMAC_L_XOR: return a ^ b;
      DMAC_L_XNOR: return ~(a ^ b);
      DMAC_L_NAND: return ~(a & b);
      DMAC_L_NOR: return ~(a | b);
      DMAC_L_NXAND: return ~a & b;
      DMAC_L_ANDNZ: return a & ~b;
      DMAC_L_NXOR: return ~a | b;
      DMAC_L_ORNZ: return a | ~b;
      default: return a ^ b;
    endcase
  endfunction

  // -------------------------------------------------------------------------
  // Lane adders
  // -------------------------------------------------------------------------
  logic [`DMAC_LANES-1:0] cin;
  logic [`DMAC_P_W-1:0] sum;

  assign cin[0] = sub;

  // Carries stop at lane boundaries.
  // Subtraction is Z minus X, formed as Z plus inverted X plus one per lane.
  genvar g;
  generate
    for (g = 0; g < `DMAC_LANES; g++) begin : g_lane
      if (g > 0) begin : g_chain
        assign cin[g] = lane_break(g, simd) ? sub : carry[g-1];
      end
      assign {carry[g], sum[g*`DMAC_LANE_W +: `DMAC_LANE_W]} =
          {1'b0, z[g*`DMAC_LANE_W +: `DMAC_LANE_W]} +
          {1'b0, x[g*`DMAC_LANE_W +: `DMAC_LANE_W] ^ {`DMAC_LANE_W{sub}}} +
          {{`DMAC_LANE_W{1'b0}}, cin[g]};
    end
  endgenerate

  assign res = logic_en ? lfn_eval(lfn, x, z) : sum;

endmodule

// ===== core/dmac_slice.sv
// Multiply-accumulate slice: pre-adder, signed multiplier, lane-split ALU,
// wide XOR, pattern detector and cascade ports, with optional pipelining.
// Assumes fabric logic drives every input synchronously to clk.
//
// Functional notes
// - Signed 27 by 18 multiplier producing the full signed product.
// - A 48-bit accumulator adds successive results into a running sum.
// - Multiplier may be bypassed at run time; 48-bit operands go straight in.
// - SIMD splits into two 24-bit or four 12-bit carry-isolated lanes.
// - Logic unit computes one of ten bitwise functions of both operands.
// - Pre-adder combines two inputs ahead of the multiplier.
// - 96-bit XOR reduction over 12, 24, 48 or 96-bit segments.
// - 48-bit pattern detector compares the result, usable for rounding.
// - Pattern detector on logic unit output gives 96-input logic functions.
// - Accumulator counts up or down each enabled clock edge.
// - Optional pipeline stages and cascade ports to neighbour slices.
`timescale 1ns/100ps
`include "dmac_defines.svh"

module dmac_slice
  import dmac_pkg::*;
#(
  parameter int IREG = 1,
  parameter int MREG = 1
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic srst,
  input wire logic ce_in,
  input wire logic ce_m,
  input wire logic ce_p,
  input wire logic [`DMAC_A_W-1:0] a_in,
  input wire logic [`DMAC_A_W-1:0] d_in,
  input wire logic [`DMAC_B_W-1:0] b_in,
  input wire logic [`DMAC_P_W-1:0] ab_in,
  input wire logic [`DMAC_P_W-1:0] c_in,
  input wire logic [`DMAC_P_W-1:0] pcin,
  input wire dmac_pre_t pre_mode,
  input wire logic use_mult,
  input wire dmac_zsel_t zsel,
  input wire dmac_simd_t simd,
  input wire logic sub,
  input wire logic logic_en,
  input wire dmac_lfn_t lfn,
  input wire logic cnt_en,
  input wire logic cnt_up,
  input wire dmac_xw_t xor_w,
  input wire logic [`DMAC_P_W-1:0] pattern,
  input wire logic [`DMAC_P_W-1:0] mask,
  output logic [`DMAC_P_W-1:0] p_out,
  output logic [`DMAC_P_W-1:0] pcout,
  output logic [`DMAC_LANES-1:0] carry_out,
  output logic [`DMAC_XSEG-1:0] xor_out,
  output logic pat_det,
  output logic patb_det
);

  // -------------------------------------------------------------------------
  // Declarations
  // -------------------------------------------------------------------------
  logic [`DMAC_A_W-1:0] a_r, a_nxt, d_r, d_nxt;
  logic [`DMAC_B_W-1:0] b_r, b_nxt;
  logic [`DMAC_P_W-1:0] ab_r, ab_nxt, c_r, c_nxt;
  logic signed [`DMAC_PROD_W-1:0] m_r, m_nxt;
  logic [`DMAC_P_W-1:0] p_r, p_nxt;
  logic [`DMAC_LANES-1:0] cy_r, cy_nxt;
  logic [`DMAC_XSEG-1:0] xr_r, xr_nxt;
  logic pd_r, pd_nxt, pbd_r, pbd_nxt;
  logic [`DMAC_A_W-1:0] a_s, d_s, ad_val;
  logic [`DMAC_B_W-1:0] b_s;
  logic [`DMAC_P_W-1:0] ab_s, c_s;
  logic signed [`DMAC_PROD_W-1:0] m_prod, m_s;
  logic [`DMAC_P_W-1:0] x_op, z_op, alu_res;
  logic [`DMAC_LANES-1:0] alu_cy;
  logic alu_sub, alu_logic;
  dmac_simd_t alu_simd;
  logic [`DMAC_XOR_W-1:0] xv;
  logic [`DMAC_XSEG-1:0] seg;
  logic [`DMAC_XSEG-1:0] xor_val;
  logic pd_val, pbd_val;

  // -------------------------------------------------------------------------
  // Operand path
  // -------------------------------------------------------------------------
  // Input and multiplier stages are skipped when their parameter is 0.
  assign a_s = (IREG != 0) ? a_r : a_in;
  assign d_s = (IREG != 0) ? d_r : d_in;
  assign b_s = (IREG != 0) ? b_r : b_in;
  assign ab_s = (IREG != 0) ? ab_r : ab_in;
  assign c_s = (IREG != 0) ? c_r : c_in;
  assign m_s = (MREG != 0) ? m_r : m_prod;

  // Pre-adder wraps at 27 bits, so the multiplier never sees an extra bit.
  always_comb begin
    case (pre_mode)
      DMAC_PRE_ADD: ad_val = d_s + a_s;
      DMAC_PRE_SUB: ad_val = d_s - a_s;
      default: ad_val = a_s;
    endcase
  end

  assign m_prod = $signed(ad_val) * $signed(b_s);

  // Counting overrides the operand muxes so the adder serves as the counter.
  always_comb begin
    if (cnt_en) begin
      x_op = `DMAC_ONE_P;
    end else if (use_mult) begin
      x_op = {{`DMAC_EXT_W{m_s[`DMAC_PROD_W-1]}}, m_s};
    end else begin
      x_op = ab_s;
    end
    // Z operand: result register, C, cascade input from the neighbour slice, or zero.
    case (zsel)
      DMAC_Z_P: z_op = p_r;
      DMAC_Z_C: z_op = c_s;
      DMAC_Z_PCIN: z_op = pcin;
      default: z_op = `DMAC_ZERO_P;
    endcase
    if (cnt_en) begin
      z_op = p_r;
    end
  end

  // Count direction drives the subtract input.
  assign alu_sub = cnt_en ? !cnt_up : sub;
  assign alu_simd = cnt_en ? DMAC_ONE48 : simd;
  assign alu_logic = logic_en && !cnt_en;

  dmac_alu u_alu (
    .x(x_op),
    .z(z_op),
    .simd(alu_simd),
    .sub(alu_sub),
    .logic_en(alu_logic),
    .lfn(lfn),
    .res(alu_res),
    .carry(alu_cy)
  );

  // -------------------------------------------------------------------------
  // Wide XOR and pattern detector
  // -------------------------------------------------------------------------
  assign xv = {x_op, z_op};

  genvar g;
  generate
    for (g = 0; g < `DMAC_XSEG; g++) begin : g_xseg
      assign seg[g] = ^xv[g*`DMAC_LANE_W +: `DMAC_LANE_W];
    end
  endgenerate

  // Wider widths fold the 12-bit partials; unused upper bits read as zero.
  always_comb begin
    xor_val = `DMAC_ZERO_X;
    case (xor_w)
      DMAC_XW12: xor_val = seg;
      DMAC_XW24: begin
        for (int i = 0; i < 4; i++) begin
          xor_val[i] = seg[2*i] ^ seg[2*i+1];
        end
      end
      DMAC_XW48: begin
        xor_val[0] = ^seg[3:0];
        xor_val[1] = ^seg[7:4];
      end
      default: xor_val[0] = ^seg;
    endcase
  end

  // Masked compare against pattern and its complement.
  // On logic output, an AND of X and Z compares 96 inputs at once.
  assign pd_val = ((alu_res ^ pattern) & ~mask) == `DMAC_ZERO_P;
  assign pbd_val = ((alu_res ^ ~pattern) & ~mask) == `DMAC_ZERO_P;

  // -------------------------------------------------------------------------
  // Pipeline registers
  // -------------------------------------------------------------------------
  // Synchronous reset wins over the enables so a stalled pipe can still be flushed.
  always_comb begin
    a_nxt = a_r;
    d_nxt = d_r;
    b_nxt = b_r;
    ab_nxt = ab_r;
    c_nxt = c_r;
    m_nxt = m_r;
    p_nxt = p_r;
    cy_nxt = cy_r;
    xr_nxt = xr_r;
    pd_nxt = pd_r;
    pbd_nxt = pbd_r;
    if (srst) begin
      a_nxt = `DMAC_ZERO_A;
      d_nxt = `DMAC_ZERO_A;
      b_nxt = `DMAC_ZERO_B;
      ab_nxt = `DMAC_ZERO_P;
      c_nxt = `DMAC_ZERO_P;
      m_nxt = `DMAC_ZERO_M;
      p_nxt = `DMAC_ZERO_P;
      cy_nxt = `DMAC_ZERO_CY;
      xr_nxt = `DMAC_ZERO_X;
      pd_nxt = 1'b0;
      pbd_nxt = 1'b0;
    end else begin
      if (ce_in) begin
        a_nxt = a_in;
        d_nxt = d_in;
        b_nxt = b_in;
        ab_nxt = ab_in;
        c_nxt = c_in;
      end
      if (ce_m) begin
        m_nxt = m_prod;
      end
      // Result register closes the accumulate loop.
      if (ce_p) begin
        p_nxt = alu_res;
        cy_nxt = alu_cy;
        xr_nxt = xor_val;
        pd_nxt = pd_val;
        pbd_nxt = pbd_val;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      a_r <= `DMAC_ZERO_A;
      d_r <= `DMAC_ZERO_A;
      b_r <= `DMAC_ZERO_B;
      ab_r <= `DMAC_ZERO_P;
      c_r <= `DMAC_ZERO_P;
      m_r <= `DMAC_ZERO_M;
      p_r <= `DMAC_ZERO_P;
      cy_r <= `DMAC_ZERO_CY;
      xr_r <= `DMAC_ZERO_X;
      pd_r <= 1'b0;
      pbd_r <= 1'b0;
    end else begin
      a_r <= a_nxt;
      d_r <= d_nxt;
      b_r <= b_nxt;
      ab_r <= ab_nxt;
      c_r <= c_nxt;
      m_r <= m_nxt;
      p_r <= p_nxt;
      cy_r <= cy_nxt;
      xr_r <= xr_nxt;
      pd_r <= pd_nxt;
      pbd_r <= pbd_nxt;
    end
  end

  assign p_out = p_r;
  assign pcout = p_r;
  assign carry_out = cy_r;
  assign xor_out = xr_r;
  assign pat_det = pd_r;
  assign patb_det = pbd_r;

  // -------------------------------------------------------------------------
  // Assertions
  // -------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_load;
    ce_p && !srst;
  endsequence
  sequence s_count_up;
    s_load ##0 cnt_en && cnt_up;
  endsequence
  sequence s_arith;
    s_load ##0 !cnt_en && !logic_en && !sub;
  endsequence

  a_mult_product: assert property (ce_m && !srst |=>
      m_r == $signed($past(ad_val)) * $signed($past(b_s)))
    else $error("multiplier register differs from signed product");
  a_acc_sum: assert property (s_arith ##0 simd == DMAC_ONE48 && zsel == DMAC_Z_P |=>
      p_r == $past(p_r) + $past(x_op))
    else $error("accumulator did not add the operand");
  a_bypass_path: assert property (s_arith ##0 !use_mult && zsel == DMAC_Z_C &&
      simd == DMAC_ONE48 |=> p_r == $past(ab_s) + $past(c_s))
    else $error("bypass did not route the wide operand");
  a_simd_lanes: assert property (s_arith ##0 simd == DMAC_FOUR12 |=>
      p_r[23:12] == `DMAC_LANE_W'($past(x_op) >> `DMAC_LANE_W) +
      `DMAC_LANE_W'($past(z_op) >> `DMAC_LANE_W))
    else $error("carry crossed a twelve-bit lane");
  a_logic_xor: assert property (s_load ##0 logic_en && !cnt_en && lfn == DMAC_L_XOR |=>
      p_r == ($past(x_op) ^ $past(z_op)))
    else $error("logic unit xor result wrong");
  a_pre_add: assert property (pre_mode == DMAC_PRE_ADD && ce_m && !srst |=>
      m_r == $signed($past(d_s) + $past(a_s)) * $signed($past(b_s)))
    else $error("pre-adder sum wrong");
  a_xor_full: assert property (s_load ##0 xor_w == DMAC_XW96 |=>
      xor_out[0] == ^$past(xv) && xor_out[7:1] == 7'h00)
    else $error("full-width xor wrong");
  a_pat_match: assert property (s_load |=>
      pat_det == ((($past(alu_res) ^ $past(pattern)) & ~$past(mask)) == `DMAC_ZERO_P))
    else $error("pattern detect wrong");
  a_count_up: assert property (s_count_up ##1 s_count_up |=>
      p_out == $past(p_r, 2) + `DMAC_TWO_P)
    else $error("counter did not step by one per edge");
  a_cascade_out: assert property (s_arith ##0 !use_mult && zsel == DMAC_Z_PCIN |=>
      pcout == $past(pcin) + $past(ab_s) || $past(simd) != DMAC_ONE48)
    else $error("cascade sum wrong");
  a_pipe_hold: assert property ((!srst && !ce_p) [*2] |=> $stable(p_r))
    else $error("result register changed without enable");
  a_sync_clear: assert property (srst |=> p_r == `DMAC_ZERO_P && m_r == `DMAC_ZERO_M)
    else $error("synchronous reset did not clear");

endmodule

// ===== shared/dmac_defines.svh
// Widths, reset values and segment counts of the multiply-accumulate slice.
// Assumes it is included by bare name wherever these constants are needed.
`ifndef DMAC_DEFINES_SVH
`define DMAC_DEFINES_SVH

// ---------------------------------------------------------------------------
// Operand and result widths
// ---------------------------------------------------------------------------
`define DMAC_A_W 27
`define DMAC_B_W 18
`define DMAC_PROD_W 45
`define DMAC_P_W 48
`define DMAC_EXT_W 3
`define DMAC_XOR_W 96

// ---------------------------------------------------------------------------
// Lane and segment layout
// ---------------------------------------------------------------------------
`define DMAC_LANE_W 12
`define DMAC_LANES 4
`define DMAC_XSEG 8

// ---------------------------------------------------------------------------
// Reset and constant values
// ---------------------------------------------------------------------------
`define DMAC_ZERO_A 27'h0
`define DMAC_ZERO_B 18'h0
`define DMAC_ZERO_M 45'h0
`define DMAC_ZERO_P 48'h0
`define DMAC_ZERO_CY 4'h0
`define DMAC_ZERO_X 8'h0
`define DMAC_ONE_P 48'h1
`define DMAC_TWO_P 48'h2

`endif

// ===== shared/dmac_pkg.sv
// Types shared by the multiply-accumulate slice and its arithmetic unit.
// Assumes nothing beyond a SystemVerilog compiler.
package dmac_pkg;

  // -------------------------------------------------------------------------
  // Mode selections
  // -------------------------------------------------------------------------
  typedef enum logic [1:0] {
    DMAC_ONE48 = 2'h0,
    DMAC_TWO24 = 2'h1,
    DMAC_FOUR12 = 2'h2
  } dmac_simd_t;

  typedef enum logic [1:0] {
    DMAC_Z_ZERO = 2'h0,
    DMAC_Z_P = 2'h1,
    DMAC_Z_C = 2'h2,
    DMAC_Z_PCIN = 2'h3
  } dmac_zsel_t;

  typedef enum logic [1:0] {
    DMAC_PRE_A = 2'h0,
    DMAC_PRE_ADD = 2'h1,
    DMAC_PRE_SUB = 2'h2
  } dmac_pre_t;

  typedef enum logic [1:0] {
    DMAC_XW12 = 2'h0,
    DMAC_XW24 = 2'h1,
    DMAC_XW48 = 2'h2,
    DMAC_XW96 = 2'h3
  } dmac_xw_t;

  typedef enum logic [3:0] {
    DMAC_L_AND = 4'h0,
    DMAC_L_OR = 4'h1,
    DMAC_L_XOR = 4'h2,
    DMAC_L_XNOR = 4'h3,
    DMAC_L_NAND = 4'h4,
    DMAC_L_NOR = 4'h5,
    DMAC_L_NXAND = 4'h6,
    DMAC_L_ANDNZ = 4'h7,
    DMAC_L_NXOR = 4'h8,
    DMAC_L_ORNZ = 4'h9
  } dmac_lfn_t;

endpackage

// ===== tb/dmac_fabric.sv
// Fabric-side model of a neighbouring slice that feeds the cascade input.
// Assumes the bench loads it synchronously on the shared clock.
`timescale 1ns/100ps

module dmac_fabric (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ld,
  input wire logic [47:0] ld_val,
  output logic [47:0] pcin
);
  // --------------------------------------------------------------------
  // Neighbour result register
  // --------------------------------------------------------------------
  // cascade neighbour output
  // A real neighbour changes only on a clock edge, so the value is registered.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pcin <= 48'h0;
    end else if (ld) begin
      pcin <= ld_val;
    end
  end
endmodule

// ===== tb/dsp_multiply_accumulate_slice_bench.sv
// Self-checking bench of the multiply-accumulate slice.
// Assumes default pipelining (input and multiplier registers present).
`timescale 1ns/100ps
`include "dmac_defines.svh"

module dsp_multiply_accumulate_slice_bench;
  import dmac_pkg::*;
  // --------------------------------------------------------------------
  // Stimulus and result signals
  // --------------------------------------------------------------------
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic srst = 1'b0, ce_in = 1'b1, ce_m = 1'b1, ce_p = 1'b1, ld = 1'b0;
  logic use_mult = 1'b0, sub = 1'b0, logic_en = 1'b0, cnt_en = 1'b0, cnt_up = 1'b0;
  logic [26:0] a_in = 27'h0, d_in = 27'h0;
  logic [17:0] b_in = 18'h0;
  logic [47:0] ab_in = 48'h0, c_in = 48'h0, pattern = 48'h0, mask = 48'h0, ld_val = 48'h0;
  dmac_pre_t pre_mode = DMAC_PRE_A;
  dmac_zsel_t zsel = DMAC_Z_ZERO;
  dmac_simd_t simd = DMAC_ONE48;
  dmac_lfn_t lfn = DMAC_L_AND;
  dmac_xw_t xor_w = DMAC_XW12;
  logic [47:0] p_out, pcout, pcin;
  logic [3:0] carry_out;
  logic [7:0] xor_out;
  logic pat_det, patb_det;
  int fails = 0, checks_done = 0, cycles = 0;

  dmac_slice dmac_slice_inst (.clk, .resetn, .srst, .ce_in, .ce_m, .ce_p, .a_in, .d_in,
    .b_in, .ab_in, .c_in, .pcin, .pre_mode, .use_mult, .zsel, .simd, .sub, .logic_en,
    .lfn, .cnt_en, .cnt_up, .xor_w, .pattern, .mask, .p_out, .pcout, .carry_out,
    .xor_out, .pat_det, .patb_det);
  dmac_fabric dmac_fabric_inst (.clk, .resetn, .ld, .ld_val, .pcin);

  // Clock of 5 ns and a cycle ceiling far above the expected run length.
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      $display("FAIL at %0t: timeout", $time);
      complete_run();
    end
  end

  // --------------------------------------------------------------------
  // Compare, reference and closing tasks
  // --------------------------------------------------------------------
  task automatic chk48(input logic [47:0] got, input logic [47:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("FAIL at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    chk48({40'h0, got}, {40'h0, exp}, what);
  endtask

  // Two's complement product of the pre-adder output and b.
  function automatic logic [47:0] prod_exp(logic [26:0] a, logic [26:0] d, logic [17:0] b,
      int m);
    logic [26:0] pre;
    logic signed [47:0] r;
    pre = (m == 1) ? d + a : (m == 2) ? d - a : a;
    r = $signed(pre) * $signed(b);
    return r;
  endfunction

  // Lane-wise Z plus or minus X; the top four bits carry the 12-bit lane carries.
  function automatic logic [51:0] simd_exp(logic [47:0] z, logic [47:0] x, int nl, logic s);
    int lw;
    logic [47:0] m, r, zi, xi;
    logic [48:0] e;
    logic [3:0] cy;
    lw = 48 / nl;
    m = (48'h1 << lw) - 48'h1;
    r = 48'h0;
    cy = 4'h0;
    for (int i = 0; i < nl; i++) begin
      zi = (z >> (i * lw)) & m;
      xi = (x >> (i * lw)) & m;
      e = s ? zi + (~xi & m) + 48'h1 : zi + xi;
      r |= (e[47:0] & m) << (i * lw);
      if (lw == 12) cy[i] = e[12];
    end
    return {cy, r};
  endfunction

  function automatic logic [47:0] lfn_exp(logic [47:0] x, logic [47:0] z, int f);
    case (f)
      0: return x & z;
      1: return x | z;
      2: return x ^ z;
      3: return ~(x ^ z);
      4: return ~(x & z);
      5: return ~(x | z);
      6: return ~x & z;
      7: return x & ~z;
      8: return ~x | z;
      default: return x | ~z;
    endcase
  endfunction

  function automatic logic [7:0] xor_exp(logic [95:0] v, int w);
    int sw;
    logic [95:0] m;
    logic [7:0] r;
    sw = 12 << w;
    m = (96'h1 << sw) - 96'h1;
    r = 8'h0;
    for (int i = 0; i < 96 / sw; i++) r[i] = ^((v >> (i * sw)) & m);
    return r;
  endfunction

  task automatic complete_run();
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Common mode, applied just after a rising edge; each control is written once per edge.
  task automatic base(input logic um, input dmac_zsel_t zs, input logic le, input dmac_pre_t pm,
      input dmac_simd_t sm, input logic sb, input logic cep, input logic sr);
    srst <= sr;
    ce_in <= 1'b1;
    ce_m <= 1'b1;
    ce_p <= cep;
    use_mult <= um;
    zsel <= zs;
    simd <= sm;
    sub <= sb;
    logic_en <= le;
    cnt_en <= 1'b0;
    pre_mode <= pm;
  endtask

  // Four edges give steady operands time to pass all three pipeline stages.
  task automatic settle();
    repeat (4) @(posedge clk);
    #1;
  endtask

  // --------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------
  task automatic t_mult();
    for (int m = 0; m < 3; m++) begin
      @(posedge clk);
      base(1'b1, DMAC_Z_ZERO, 1'b0, dmac_pre_t'(m), DMAC_ONE48, 1'b0, 1'b1, 1'b0);
      a_in <= 27'h4000000;
      d_in <= 27'h0000123;
      b_in <= 18'h3FFFD;
      settle();
      chk48(p_out, prod_exp(27'h4000000, 27'h0000123, 18'h3FFFD, m), "product");
    end
    $display("test mult done");
  endtask

  task automatic t_simd();
    logic [51:0] r;
    for (int k = 0; k < 6; k++) begin
      @(posedge clk);
      base(1'b0, DMAC_Z_C, 1'b0, DMAC_PRE_A, dmac_simd_t'(k % 3), k >= 3, 1'b1, 1'b0);
      ab_in <= 48'h800FFF_FFF801;
      c_in <= 48'h800001_001FFF;
      settle();
      r = simd_exp(48'h800001_001FFF, 48'h800FFF_FFF801, 1 << (k % 3), k >= 3);
      chk48(p_out, r[47:0], "lane sum");
      if (k % 3 == 2) chk8({4'h0, carry_out}, {4'h0, r[51:48]}, "carry");
    end
    $display("test simd done");
  endtask

  task automatic t_logic();
    for (int f = 0; f < 10; f++) begin
      @(posedge clk);
      base(1'b0, DMAC_Z_C, 1'b1, DMAC_PRE_A, DMAC_ONE48, 1'b0, 1'b1, 1'b0);
      lfn <= dmac_lfn_t'(f);
      xor_w <= dmac_xw_t'(f % 4);
      ab_in <= 48'h5A3C_0F96_E1D2;
      c_in <= 48'h33CC_F00F_8421;
      settle();
      chk48(p_out, lfn_exp(48'h5A3C_0F96_E1D2, 48'h33CC_F00F_8421, f), "logic");
      chk8(xor_out, xor_exp({48'h5A3C_0F96_E1D2, 48'h33CC_F00F_8421}, f % 4), "xor");
    end
    $display("test logic done");
  endtask

  // wide AND judged by the detector
  task automatic t_pattern();
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      base(1'b0, DMAC_Z_C, 1'b1, DMAC_PRE_A, DMAC_ONE48, 1'b0, 1'b1, 1'b0);
      lfn <= DMAC_L_AND;
      ab_in <= 48'hFFFF_FFFF_FFFF;
      c_in <= (k == 0) ? 48'hFFFF_FFFF_FFFF : (k == 3) ? 48'h0 : 48'hFFFF_FFFF_FFDF;
      pattern <= 48'hFFFF_FFFF_FFFF;
      mask <= (k == 2) ? 48'h20 : 48'h0;
      settle();
      chk8({6'h0, pat_det, patb_det}, {6'h0, k == 0 || k == 2, k == 3}, "flags");
    end
    $display("test pattern done");
  endtask

  task automatic t_count();
    @(posedge clk);
    base(1'b0, DMAC_Z_C, 1'b0, DMAC_PRE_A, DMAC_ONE48, 1'b0, 1'b1, 1'b1);
    @(posedge clk);
    srst <= 1'b0;
    cnt_en <= 1'b1;
    cnt_up <= 1'b1;
    repeat (5) @(posedge clk);
    cnt_up <= 1'b0;
    repeat (7) @(posedge clk);
    cnt_en <= 1'b0;
    #1;
    chk48(p_out, 48'hFFFF_FFFF_FFFE, "count");
    $display("test count done");
  endtask

  task automatic t_accum();
    logic [47:0] pr;
    pr = prod_exp(27'h1234567, 27'h0, 18'h2ABCD, 0);
    @(posedge clk);
    base(1'b1, DMAC_Z_P, 1'b0, DMAC_PRE_A, DMAC_ONE48, 1'b0, 1'b0, 1'b1);
    a_in <= 27'h1234567;
    b_in <= 18'h2ABCD;
    @(posedge clk);
    srst <= 1'b0;
    repeat (3) @(posedge clk);
    ce_p <= 1'b1;
    repeat (3) @(posedge clk);
    ce_p <= 1'b0;
    #1;
    chk48(p_out, pr * 3, "accumulate");
    @(posedge clk);
    srst <= 1'b1;
    #1;
    chk48(p_out, pr * 3, "hold");
    @(posedge clk);
    srst <= 1'b0;
    #1;
    chk48(p_out, 48'h0, "sync clear");
    $display("test accum done");
  endtask

  task automatic t_cascade();
    @(posedge clk);
    base(1'b0, DMAC_Z_PCIN, 1'b0, DMAC_PRE_A, DMAC_ONE48, 1'b0, 1'b1, 1'b0);
    ab_in <= 48'h1;
    ld <= 1'b1;
    ld_val <= 48'h7FFF_FFFF_FFFF;
    @(posedge clk);
    ld <= 1'b0;
    settle();
    chk48(p_out, 48'h8000_0000_0000, "cascade sum");
    chk48(pcout, 48'h8000_0000_0000, "cascade out");
    $display("test cascade done");
  endtask

  // --------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    chk48(p_out, 48'h0, "reset");
    resetn <= 1'b1;
    t_mult();
    t_simd();
    t_logic();
    t_pattern();
    t_count();
    t_accum();
    t_cascade();
    complete_run();
  end
endmodule
